// *** include/srv_pkg.sv ***
// constants, types and register map of the sector read/verify command block
package srv_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] OFS_DATA_ACK = 8'h00;
  localparam logic [7:0] OFS_FEATURE  = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO  = 8'h0C;
  localparam logic [7:0] OFS_ADDR_MID = 8'h10;
  localparam logic [7:0] OFS_ADDR_HI  = 8'h14;
  localparam logic [7:0] OFS_DEVHEAD  = 8'h18;
  localparam logic [7:0] OFS_CMD_STAT = 8'h1C;
  localparam logic [7:0] OFS_ERROR    = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_CONTROL  = 8'h2C;

  // command opcodes
  localparam logic [7:0] OP_READ_EXT   = 8'h24;
  localparam logic [7:0] OP_VERIFY     = 8'h40;
  localparam logic [7:0] OP_VERIFY_NR  = 8'h41;
  localparam logic [7:0] OP_VERIFY_EXT = 8'h42;

  // device/head fields
  localparam int DEV_MODE_BIT = 6;
  localparam int DEV_DRV_BIT  = 4;
  // status fields
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  // error register fields
  localparam int ER_ABRT = 2;
  localparam int ER_UNC  = 6;
  // control register fields
  localparam int CTL_HOB = 0;
  localparam int CTL_DRV = 1;
  // interrupt status/mask fields
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DRQ  = 1;
  localparam int IRQ_ERR  = 2;
  localparam int IRQ_W    = 3;

  // geometry of the translated chs mode
  localparam logic [3:0]  CHS_LAST_HEAD   = 4'hF;
  localparam logic [7:0]  CHS_LAST_SECTOR = 8'h3F;
  localparam logic [7:0]  CHS_FIRST_SECT  = 8'h01;
  // sector counts written as zero mean the full range
  localparam logic [16:0] FULL_COUNT_28   = 17'h00100;
  localparam logic [16:0] FULL_COUNT_48   = 17'h10000;
  localparam logic [16:0] ONE_SECTOR      = 17'h00001;

  typedef enum logic [1:0] {
    MODE_CHS,
    MODE_LBA28,
    MODE_LBA48
  } addr_mode_t;

  // request handed to the media engine
  typedef struct packed {
    logic [47:0] addr;
    logic        xfer;
  } media_req_t;
endpackage

// *** verilog/srv_addr_step.sv ***
// next-sector address in chs, 28-bit or 48-bit addressing
`timescale 1ns/1ps
`default_nettype none
module srv_addr_step
  import srv_pkg::*;
(
  input  wire addr_mode_t  mode_i,
  input  wire logic [47:0] addr_i,
  output logic      [47:0] next_o
);
  // chs packing: cylinder [27:12], head [11:8], sector [7:0]
  always_comb begin
    next_o = addr_i;
    case (mode_i)
      MODE_CHS: begin
        if (addr_i[7:0] != CHS_LAST_SECTOR) begin
          next_o[7:0] = addr_i[7:0] + 8'h01;
        end else begin
          next_o[7:0] = CHS_FIRST_SECT;
          if (addr_i[11:8] != CHS_LAST_HEAD) begin
            next_o[11:8] = addr_i[11:8] + 4'h1;
          end else begin
            next_o[11:8]  = 4'h0;
            next_o[27:12] = addr_i[27:12] + 16'h0001;
          end
        end
      end
      // 28-bit wraps inside its own range, upper bits stay clear
      MODE_LBA28: next_o = {20'h00000, addr_i[27:0] + 28'h0000001};
      MODE_LBA48: next_o = addr_i + 48'h000000000001;
      default:    next_o = addr_i;
    endcase
  end
endmodule
`default_nettype wire

// *** verilog/srv_cmd_core.sv ***
// task-file registers and sector read/verify command sequencer
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - extended read uses 16-bit sector count
// - previous bytes carry address bits 47-24
// - start at given sector, then consecutive sectors
// - extended read raises DRQ even on error
// - extended read leaves last sector address
// - extended read stops at failing sector
// - 28-bit verify: no DRQ, no data
// - mode bit selects chs or 28-bit address
// - verify end clears busy, raises interrupt
// - 28-bit verify leaves last verified address
// - verify error reports failing sector address
// - verify error leaves unverified count
// - extended verify: no DRQ, 48-bit layout
// - extended verify leaves last verified address
// - extended verify failure reports error address
module srv_cmd_core
  import srv_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output media_req_t       media_o,
  output logic             media_req_o,
  input  wire logic        media_done_i,
  input  wire logic        media_err_i,
  output logic             drq_o,
  output logic             bsy_o
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_XFER, S_NEXT, S_FINISH} state_t;

  state_t      state_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [7:0]  feat_cur_r, feat_prv_r;
  logic [7:0]  cnt_cur_r, cnt_prv_r;
  logic [7:0]  lo_cur_r, lo_prv_r;
  logic [7:0]  mid_cur_r, mid_prv_r;
  logic [7:0]  hi_cur_r, hi_prv_r;
  logic [7:0]  dev_r;
  logic [7:0]  err_r;
  logic [1:0]  ctl_r;
  logic [IRQ_W-1:0] isr_r, imr_r;
  logic        irq_r;
  logic        bsy_r, drq_r, errst_r;
  logic        ext_r, xfer_r, sec_err_r, media_req_r;
  addr_mode_t  mode_r, mode_nxt;
  logic [47:0] work_addr_r, addr_nxt, step_addr;
  logic [16:0] remain_r, count_nxt;

  logic        req, wr, rd, wr_cmd, drv_match, op_ok, start;
  logic [7:0]  wbyte;
  logic [IRQ_W-1:0] irq_set;

  ////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack dropped the cycle after
  assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr     = req & wb_we_i & wb_sel_i[0];
  assign rd     = req & ~wb_we_i;
  assign wbyte  = wb_dat_i[7:0];
  assign wr_cmd = wr & (wb_adr_i == OFS_CMD_STAT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // read mux; hob in control selects the previous bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h00000000;
    end else if (rd) begin
      dat_r <= 32'h00000000;
      case (wb_adr_i)
        OFS_FEATURE:  dat_r[7:0] <= ctl_r[CTL_HOB] ? feat_prv_r : feat_cur_r;
        OFS_COUNT:    dat_r[7:0] <= ctl_r[CTL_HOB] ? cnt_prv_r : cnt_cur_r;
        OFS_ADDR_LO:  dat_r[7:0] <= ctl_r[CTL_HOB] ? lo_prv_r : lo_cur_r;
        OFS_ADDR_MID: dat_r[7:0] <= ctl_r[CTL_HOB] ? mid_prv_r : mid_cur_r;
        OFS_ADDR_HI:  dat_r[7:0] <= ctl_r[CTL_HOB] ? hi_prv_r : hi_cur_r;
        OFS_DEVHEAD:  dat_r[7:0] <= dev_r;
        OFS_CMD_STAT: begin
          dat_r[ST_BSY]  <= bsy_r;
          dat_r[ST_DRDY] <= ~bsy_r;
          dat_r[ST_DRQ]  <= drq_r;
          dat_r[ST_ERR]  <= errst_r;
        end
        OFS_ERROR:    dat_r[7:0] <= err_r;
        OFS_IRQ_STAT: dat_r[IRQ_W-1:0] <= isr_r;
        OFS_IRQ_MASK: dat_r[IRQ_W-1:0] <= imr_r;
        OFS_CONTROL:  dat_r[1:0] <= ctl_r;
        default:      dat_r <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command decode
  assign drv_match = (dev_r[DEV_DRV_BIT] == ctl_r[CTL_DRV]);
  assign op_ok     = (wbyte == OP_READ_EXT) | (wbyte == OP_VERIFY) |
                     (wbyte == OP_VERIFY_NR) | (wbyte == OP_VERIFY_EXT);
  // a command for the other drive is simply not taken
  assign start     = wr_cmd & ~bsy_r & drv_match & op_ok;

  // start address and count from the task file
  always_comb begin
    mode_nxt  = MODE_CHS;
    addr_nxt  = 48'h000000000000;
    count_nxt = {9'h000, cnt_cur_r};
    if ((wbyte == OP_READ_EXT) | (wbyte == OP_VERIFY_EXT)) begin
      mode_nxt  = MODE_LBA48;
      // previous bytes are the upper half of the address
      addr_nxt  = {hi_prv_r, mid_prv_r, lo_prv_r, hi_cur_r, mid_cur_r, lo_cur_r};
      // 16-bit count, zero meaning the full range
      count_nxt = {1'b0, cnt_prv_r, cnt_cur_r};
      if ({cnt_prv_r, cnt_cur_r} == 16'h0000) begin
        count_nxt = FULL_COUNT_48;
      end
    end else begin
      if (cnt_cur_r == 8'h00) begin
        count_nxt = FULL_COUNT_28;
      end
      // mode bit picks logical or cylinder/head/sector
      if (dev_r[DEV_MODE_BIT]) begin
        mode_nxt = MODE_LBA28;
        addr_nxt = {20'h00000, dev_r[3:0], hi_cur_r, mid_cur_r, lo_cur_r};
      end else begin
        addr_nxt = {20'h00000, hi_cur_r, mid_cur_r, dev_r[3:0], lo_cur_r};
      end
    end
  end

  srv_addr_step u_step (
    .mode_i (mode_r),
    .addr_i (work_addr_r),
    .next_o (step_addr)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer: one sector per pass through issue/wait/next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= S_IDLE;
      work_addr_r <= 48'h000000000000;
      remain_r    <= 17'h00000;
      mode_r      <= MODE_CHS;
      ext_r       <= 1'b0;
      xfer_r      <= 1'b0;
      sec_err_r   <= 1'b0;
      media_req_r <= 1'b0;
      drq_r       <= 1'b0;
      bsy_r       <= 1'b0;
    end else begin
      media_req_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            work_addr_r <= addr_nxt; // start at the given sector
            remain_r    <= count_nxt;
            mode_r      <= mode_nxt;
            ext_r       <= (mode_nxt == MODE_LBA48);
            // only the extended read moves data
            xfer_r      <= (wbyte == OP_READ_EXT);
            sec_err_r   <= 1'b0;
            bsy_r       <= 1'b1;
            state_r     <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          media_req_r <= 1'b1;
          state_r     <= S_WAIT;
        end
        S_WAIT: begin
          if (media_done_i) begin
            sec_err_r <= media_err_i;
            if (xfer_r) begin
              drq_r   <= 1'b1; // raised whatever the outcome
              state_r <= S_XFER;
            end else begin
              state_r <= S_NEXT;
            end
          end
        end
        S_XFER: begin
          if (wr & (wb_adr_i == OFS_DATA_ACK)) begin
            drq_r   <= 1'b0;
            state_r <= S_NEXT;
          end
        end
        S_NEXT: begin
          // a failing sector ends the command right there
          if (sec_err_r | (remain_r == ONE_SECTOR)) begin
            state_r <= S_FINISH;
          end else begin
            work_addr_r <= step_addr; // consecutive sectors
            remain_r    <= remain_r - ONE_SECTOR;
            state_r     <= S_ISSUE;
          end
        end
        S_FINISH: begin
          bsy_r   <= 1'b0; // done, interrupt raised alongside
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // task file: host writes while idle, address written back at finish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feat_cur_r <= 8'h00;
      feat_prv_r <= 8'h00;
      cnt_cur_r  <= 8'h00;
      cnt_prv_r  <= 8'h00;
      lo_cur_r   <= 8'h00;
      lo_prv_r   <= 8'h00;
      mid_cur_r  <= 8'h00;
      mid_prv_r  <= 8'h00;
      hi_cur_r   <= 8'h00;
      hi_prv_r   <= 8'h00;
      dev_r      <= 8'h00;
    end else if (state_r == S_FINISH) begin
      if (ext_r) begin
        // last or failing sector, all 48 bits
        {hi_prv_r, mid_prv_r, lo_prv_r} <= work_addr_r[47:24];
        {hi_cur_r, mid_cur_r, lo_cur_r} <= work_addr_r[23:0];
      end else if (mode_r == MODE_LBA28) begin
        // last or failing sector in 28-bit form
        dev_r[3:0] <= work_addr_r[27:24];
        {hi_cur_r, mid_cur_r, lo_cur_r} <= work_addr_r[23:0];
      end else begin
        // cylinder/head/sector form
        {hi_cur_r, mid_cur_r} <= work_addr_r[27:12];
        dev_r[3:0] <= work_addr_r[11:8];
        lo_cur_r   <= work_addr_r[7:0];
      end
      // sectors left unchecked, the failing one included
      if (sec_err_r) begin
        cnt_cur_r <= remain_r[7:0];
        if (ext_r) begin
          cnt_prv_r <= remain_r[15:8];
        end
      end
    end else if (wr & ~bsy_r) begin
      // each feature, count or address byte write pushes the current value to previous
      case (wb_adr_i)
        OFS_FEATURE: begin
          feat_prv_r <= feat_cur_r;
          feat_cur_r <= wbyte;
        end
        OFS_COUNT: begin
          cnt_prv_r <= cnt_cur_r;
          cnt_cur_r <= wbyte;
        end
        OFS_ADDR_LO: begin
          lo_prv_r <= lo_cur_r;
          lo_cur_r <= wbyte;
        end
        OFS_ADDR_MID: begin
          mid_prv_r <= mid_cur_r;
          mid_cur_r <= wbyte;
        end
        OFS_ADDR_HI: begin
          hi_prv_r <= hi_cur_r;
          hi_cur_r <= wbyte;
        end
        OFS_DEVHEAD: dev_r <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // error register, control and error status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r   <= 8'h00;
      errst_r <= 1'b0;
    end else if (wr_cmd & ~bsy_r & drv_match) begin
      // unsupported opcodes abort at once
      err_r   <= op_ok ? 8'h00 : (8'h01 << ER_ABRT);
      errst_r <= ~op_ok;
    end else if ((state_r == S_FINISH) & sec_err_r) begin
      err_r   <= 8'h01 << ER_UNC;
      errst_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= 2'b00;
    end else if (wr & (wb_adr_i == OFS_CONTROL)) begin
      ctl_r <= wbyte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, set beats a same-cycle write-one clear
  assign irq_set[IRQ_DONE] = (state_r == S_FINISH) |
                             (wr_cmd & ~bsy_r & drv_match & ~op_ok);
  assign irq_set[IRQ_DRQ]  = (state_r == S_WAIT) & media_done_i & xfer_r;
  assign irq_set[IRQ_ERR]  = ((state_r == S_FINISH) & sec_err_r) |
                             (wr_cmd & ~bsy_r & drv_match & ~op_ok);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_r <= '0;
      imr_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (wr & (wb_adr_i == OFS_IRQ_STAT)) begin
        isr_r <= (isr_r & ~wbyte[IRQ_W-1:0]) | irq_set;
      end else begin
        isr_r <= isr_r | irq_set;
      end
      if (wr & (wb_adr_i == OFS_IRQ_MASK)) begin
        imr_r <= wbyte[IRQ_W-1:0];
      end
      irq_r <= |(isr_r & imr_r); // one cycle behind status
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;
  assign irq_o        = irq_r;
  assign media_req_o  = media_req_r;
  assign media_o.addr = work_addr_r;
  assign media_o.xfer = xfer_r;
  assign drq_o        = drq_r;
  assign bsy_o        = bsy_r;

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_verify_no_drq: assert property (@(posedge clk_i) disable iff (rst_i)
    (bsy_r && !xfer_r) |-> !drq_r) else $error("drq raised during verify");
  chk_drq_on_err: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == S_WAIT && media_done_i && xfer_r) |=> drq_r ##0 state_r == S_XFER)
    else $error("drq missing after extended read sector");
  chk_done_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(bsy_r) |-> (isr_r[IRQ_DONE] && !imr_r[IRQ_DONE]) or (isr_r[IRQ_DONE] ##1 irq_r))
    else $error("completion without interrupt");
  chk_err_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == S_NEXT && sec_err_r) |=> state_r == S_FINISH ##1 !bsy_r)
    else $error("command went on past failing sector");
  chk_ext_last_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == S_FINISH && ext_r) |=>
      {hi_prv_r, mid_prv_r, lo_prv_r, hi_cur_r, mid_cur_r, lo_cur_r} == $past(work_addr_r))
    else $error("48-bit address not written back");
  chk_err_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == S_FINISH && sec_err_r && !xfer_r) |=> cnt_cur_r == 8'($past(remain_r)))
    else $error("remaining count not written back");
  chk_drv_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_cmd && !bsy_r && !drv_match) |=> !bsy_r && state_r == S_IDLE)
    else $error("command for other drive was taken");
  chk_addr_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == S_NEXT && !sec_err_r && remain_r > ONE_SECTOR) |=>
      work_addr_r == $past(step_addr) ##1 media_req_r)
    else $error("sector address did not advance");
endmodule
`default_nettype wire

// *** verif/media_model.sv ***
// media engine model answering sector requests of the command block
`timescale 1ns/1ps
`default_nettype none
module media_model
  import srv_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire media_req_t  media_i,
  input  wire logic [47:0] err_addr_i,
  output logic             done_o,
  output logic             err_o
);
  logic [2:0] wait_r;
  logic       busy_r;
  logic       slow_r;
  logic       fail_r;

  //////////////////////////////////////////////////////////////////////////////
  // alternate prompt and slow answers so both timings reach the sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 3'h0;
      busy_r <= 1'b0;
      slow_r <= 1'b0;
      fail_r <= 1'b0;
    end else if (req_i) begin
      busy_r <= 1'b1;
      wait_r <= slow_r ? 3'h5 : 3'h0;
      slow_r <= ~slow_r;
      fail_r <= (media_i.addr == err_addr_i);
    end else if (busy_r && (wait_r != 3'h0)) begin
      wait_r <= wait_r - 3'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
    end
  end

  // error flag toggles outside done so a stale level is never trusted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      err_o  <= 1'b0;
    end else begin
      done_o <= busy_r && (wait_r == 3'h0);
      err_o  <= (busy_r && (wait_r == 3'h0)) ? fail_r : ~err_o;
    end
  end
endmodule
`default_nettype wire

// *** verif/sector_read_verify_cmds_bench.sv ***
// self-checking bench of the sector read/verify command block
`timescale 1ns/1ps
`default_nettype none
module sector_read_verify_cmds_bench;
  import srv_pkg::*;
  typedef struct {
    string       nm;
    logic [47:0] v;
  } note_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h1;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  media_req_t  media_o;
  logic        media_req_o;
  logic        media_done;
  logic        media_err;
  logic        drq_o;
  logic        bsy_o;
  logic [47:0] err_addr = '1;
  logic [47:0] base;
  logic [31:0] r;
  logic        vfy = 1'b0;
  int          err_total = 0;
  int          check_count = 0;
  note_t       rq[$];
  logic [47:0] mq[$];

  srv_cmd_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .media_o(media_o),
    .media_req_o(media_req_o), .media_done_i(media_done), .media_err_i(media_err),
    .drq_o(drq_o), .bsy_o(bsy_o));
  media_model pm (.clk_i(clk_i), .rst_i(rst_i), .req_i(media_req_o), .media_i(media_o),
    .err_addr_i(err_addr), .done_o(media_done), .err_o(media_err));

  //////////////////////////////////////////////////////////////////////////////
  // clock of 50 ns
  always #25 clk_i = ~clk_i;

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic timeout(input string nm);
    err_total++;
    $display("Error %s expected done seen timeout", nm);
    stop_test();
  endtask

  // watcher: read data and media addresses against the oldest notes
  always @(posedge clk_i) begin
    note_t n;
    if (wb_ack_o === 1'b1 && !wb_we) begin
      n = rq.pop_front();
      check(n.nm, {16'h0, wb_dat_o}, n.v);
    end
    if (media_req_o === 1'b1 && mq.size() > 0)
      check("media addr", media_o.addr, mq.pop_front());
    if (media_req_o === 1'b1)
      check("media xfer", {47'h0, media_o.xfer}, {47'h0, ~vfy});
    if (vfy && bsy_o === 1'b1)
      check("drq", {47'h0, drq_o}, 48'h0);
  end

  //////////////////////////////////////////////////////////////////////////////
  // classic cycle: hold until ack, release at that edge, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) timeout("bus ack");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] v);
    rq.push_back('{nm, {40'h0, v}});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic wait_for(input logic want_drq);
    int n;
    n = 0;
    while (n < 400 && (want_drq ? drq_o !== 1'b1 : bsy_o !== 1'b0)) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) timeout(want_drq ? "drq" : "busy");
  endtask

  // previous byte first, then current, for count and each address byte
  task automatic cmd(input logic [7:0] op, input logic [7:0] dev, input logic [15:0] c,
                     input logic [47:0] a);
    wr(OFS_IRQ_STAT, 8'h07);
    wr(OFS_COUNT, c[15:8]);
    wr(OFS_COUNT, c[7:0]);
    wr(OFS_ADDR_LO, a[31:24]);
    wr(OFS_ADDR_LO, a[7:0]);
    wr(OFS_ADDR_MID, a[39:32]);
    wr(OFS_ADDR_MID, a[15:8]);
    wr(OFS_ADDR_HI, a[47:40]);
    wr(OFS_ADDR_HI, a[23:16]);
    wr(OFS_DEVHEAD, dev);
    wr(OFS_CMD_STAT, op);
  endtask

  // one drq per sector; a task-file write while busy must be dropped
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      wait_for(1'b1);
      if (i == 0) begin
        rd("status drq", OFS_CMD_STAT, 8'h88);
        wr(OFS_FEATURE, 8'h77);
      end
      wr(OFS_DATA_ACK, 8'h00);
      @(posedge clk_i);
    end
    wait_for(1'b0);
  endtask

  task automatic fin(input logic [7:0] st, input logic [7:0] er, input logic [7:0] iq);
    rd("status", OFS_CMD_STAT, st);
    rd("error", OFS_ERROR, er);
    rd("irq status", OFS_IRQ_STAT, iq);
  endtask

  task automatic chk_addr(input logic [47:0] a, input logic ext);
    rd("addr lo", OFS_ADDR_LO, a[7:0]);
    rd("addr mid", OFS_ADDR_MID, a[15:8]);
    rd("addr hi", OFS_ADDR_HI, a[23:16]);
    if (ext) begin
      wr(OFS_CONTROL, 8'h01);
      rd("addr lo prev", OFS_ADDR_LO, a[31:24]);
      rd("addr mid prev", OFS_ADDR_MID, a[39:32]);
      rd("addr hi prev", OFS_ADDR_HI, a[47:40]);
      wr(OFS_CONTROL, 8'h00);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(73087));
    rd("count", OFS_COUNT, 8'h00);
    rd("mask", OFS_IRQ_MASK, 8'h00);
    rd("unmapped", 8'h30, 8'h00);
    wr(8'h34, 8'h55);
    // feature pair: current on plain read, previous with hob set
    wr(OFS_FEATURE, 8'h5A);
    wr(OFS_FEATURE, 8'hA5);
    rd("feature", OFS_FEATURE, 8'hA5);
    wr(OFS_CONTROL, 8'h01);
    rd("feature prev", OFS_FEATURE, 8'h5A);
    wr(OFS_CONTROL, 8'h00);
    $display("test reset done");
    // long extended read: 259 sectors crossing a byte carry
    base = 48'h0102_0300_00FE;
    for (int i = 0; i < 259; i++) mq.push_back(base + i);
    cmd(OP_READ_EXT, 8'h40, 16'h0103, base);
    run(259);
    fin(8'h40, 8'h00, 8'h03);
    chk_addr(base + 258, 1'b1);
    rd("count kept", OFS_COUNT, 8'h03);
    rd("feature kept", OFS_FEATURE, 8'hA5);
    check("irq masked", {47'h0, irq_o}, 48'h0);
    $display("test read ext done");
    // extended read failing on the second sector still raises drq
    base = 48'h0000_00FF_FFFF;
    err_addr = base + 1;
    mq.push_back(base);
    mq.push_back(base + 1);
    cmd(OP_READ_EXT, 8'h40, 16'h0004, base);
    run(2);
    fin(8'h41, 8'h40, 8'h07);
    chk_addr(base + 1, 1'b1);
    $display("test read ext error done");
    // chs verify crossing sector and head limits
    vfy = 1'b1;
    wr(OFS_IRQ_MASK, 8'h01);
    cmd(OP_VERIFY, 8'h0F, 16'h0003, 48'h0000_0000_013E);
    run(0);
    fin(8'h40, 8'h00, 8'h01);
    chk_addr(48'h0000_0000_0201, 1'b0);
    rd("devhead", OFS_DEVHEAD, 8'h00);
    @(posedge clk_i);
    check("irq set", {47'h0, irq_o}, 48'h1);
    wr(OFS_IRQ_STAT, 8'h01);
    @(posedge clk_i);
    check("irq clear", {47'h0, irq_o}, 48'h0);
    wr(OFS_IRQ_MASK, 8'h00);
    $display("test chs verify done");
    // lba28 verify failing on the second sector
    base = 48'h0000_0FFF_FFFE;
    err_addr = base + 1;
    mq.push_back(base);
    mq.push_back(base + 1);
    cmd(OP_VERIFY_NR, 8'h4F, 16'h0004, {24'h0, base[23:0]});
    run(0);
    fin(8'h41, 8'h40, 8'h05);
    chk_addr(base + 1, 1'b0);
    rd("devhead", OFS_DEVHEAD, 8'h4F);
    rd("count left", OFS_COUNT, 8'h03);
    $display("test lba28 verify done");
    // extended verify at a random address: clean pass, then a failure
    for (int j = 0; j < 2; j++) begin
      r = $urandom;
      base = {r[15:0], $urandom};
      err_addr = j ? base + 2 : '1;
      for (int i = 0; i < (j ? 3 : 2); i++) mq.push_back(base + i);
      cmd(OP_VERIFY_EXT, 8'h40, j ? 16'h0005 : 16'h0002, base);
      run(0);
      fin(j ? 8'h41 : 8'h40, j ? 8'h40 : 8'h00, j ? 8'h05 : 8'h01);
      chk_addr(base + (j ? 2 : 1), 1'b1);
      rd("count", OFS_COUNT, j ? 8'h03 : 8'h02);
    end
    vfy = 1'b0;
    $display("test verify ext done");
    // command for the other drive position is left alone
    wr(OFS_CONTROL, 8'h02);
    cmd(OP_VERIFY, 8'h40, 16'h0001, 48'h0);
    repeat (4) @(posedge clk_i);
    check("busy other drive", {47'h0, bsy_o}, 48'h0);
    rd("irq other drive", OFS_IRQ_STAT, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    // unsupported opcode aborts at once
    cmd(8'h20, 8'h40, 16'h0001, 48'h0);
    fin(8'h41, 8'h04, 8'h05);
    $display("test drive and abort done");
    stop_test();
  end
endmodule
`default_nettype wire
